// *** hdl/mqu_outbound_top.sv ***
// outbound free/post list manager with host queue port and interrupt
// Operation
// R01 - device keeps bottom and top pointers of outbound free and post lists
// R02 - processor takes free frame at free bottom, then advances it by four
// R03 - processor stores reply frame at post top, then advances it by four
// R04 - status bit set while post list holds any entry
// R05 - host interrupt only when status set and not masked
// R06 - post list non-empty exactly when bottom differs from top
// R07 - host reads queue port 0x044 to get next reply frame
// R08 - status and mask mirrored into interrupt status register zero
// R09 - processor must set routing bit so interrupt reaches the pin
// R10 - queue port read fetches post bottom entry as delayed memory read
// R11 - after each served read, post bottom advances and is compared
// R12 - status clears itself once post bottom equals post top
// R13 - queue port read on empty post list returns all ones
// R14 - host returns processed frame by writing queue port 0x044
// R15 - queue port write stored at free top, then free top advances
// R16 - low four address bits: bit 0 pull flag, bits 3:1 ignored
// R17 - inbound port write passed on unchanged as ordinary posted frame
// R18 - host posts pull frames by writing extended address to 0x040
// R19 - processor limits free frames so post list never overflows
// R20 - processor alternates pull bit on each pass of host free list
// R21 - host free list aligned to its own size
// R22 - mask bit 0 enables, 1 masks; status unaffected
// R23 - status flag is bit three of its register
// R24 - with unit disabled, status and mask registers do not answer
// R25 - pointers wrap to list start past configured size
`timescale 1ns/1ps
`default_nettype none
module mqu_outbound_top
    import mqu_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic HOST_REQ,
    input wire logic HOST_WE,
    input wire logic [mqu_pkg::SHELL_AW-1:0] HOST_ADDR,
    input wire logic [31:0] HOST_WDATA,
    output logic HOST_ACK,
    output logic HOST_NOCLAIM,
    output logic [31:0] HOST_RDATA,
    output logic HOST_IRQ,
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [31:0] MEM_ADDR,
    output logic [31:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic [31:0] MEM_RDATA,
    input wire logic LP_WE,
    input wire logic [mqu_pkg::LOC_AW-1:0] LP_ADDR,
    input wire logic [31:0] LP_WDATA,
    output logic [31:0] LP_RDATA,
    output logic IN_POST_VALID,
    output logic [31:0] IN_POST_DATA,
    output logic IN_POST_PULL,
    output logic IRQ_STAT_ALIAS,
    output logic IRQ_MASK_ALIAS
);
    typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} mqu_state_t;

    mqu_state_t state_q, state_d;
    logic msg_unit_enable_q, host_msg_irq_route_q, post_list_irq_mask_bit_q;
    logic [11:0] qbase_q;
    logic [2:0] qsize_q;
    logic [19:0] mask;
    logic [31:0] ofl_bot, ofl_top, opl_bot, opl_top;

    // host request decode
    logic take, hit_status, hit_mask, hit_inq, hit_outq;
    logic rd_outq, wr_outq, quick;
    logic post_list_service_request;
    logic opl_bot_adv, ofl_top_adv;

    assign mask = ring_mask(qsize_q);
    assign post_list_service_request = (opl_bot != opl_top); // R06 R04 R12
    // no new request while the previous answer is still on the port
    assign take = CE && HOST_REQ && (state_q == ST_IDLE) && !HOST_ACK && !HOST_NOCLAIM;
    assign hit_status = (HOST_ADDR == OFF_OPL_STATUS);
    assign hit_mask = (HOST_ADDR == OFF_OPL_MASK);
    assign hit_inq = (HOST_ADDR == OFF_IN_Q);
    assign hit_outq = (HOST_ADDR == OFF_OUT_Q);
    assign rd_outq = take && msg_unit_enable_q && hit_outq && !HOST_WE
        && post_list_service_request; // R10
    assign wr_outq = take && msg_unit_enable_q && hit_outq && HOST_WE; // R15
    assign quick = take && msg_unit_enable_q && !rd_outq && !wr_outq;
    assign opl_bot_adv = (state_q == ST_RD) && MEM_ACK; // R11
    assign ofl_top_adv = (state_q == ST_WR) && MEM_ACK; // R15

    // local register writes
    logic lw_ctrl, lw_qbase, lw_ofl_bot, lw_ofl_bot_inc, lw_ofl_top;
    logic lw_opl_bot, lw_opl_top, lw_opl_top_inc;
    assign lw_ctrl = LP_WE && (LP_ADDR == LOC_CTRL);
    assign lw_qbase = LP_WE && (LP_ADDR == LOC_QBASE);
    assign lw_ofl_bot = LP_WE && (LP_ADDR == LOC_OFL_BOT);
    assign lw_ofl_bot_inc = LP_WE && (LP_ADDR == LOC_OFL_BOT_INC); // R02
    assign lw_ofl_top = LP_WE && (LP_ADDR == LOC_OFL_TOP);
    assign lw_opl_bot = LP_WE && (LP_ADDR == LOC_OPL_BOT);
    assign lw_opl_top = LP_WE && (LP_ADDR == LOC_OPL_TOP);
    assign lw_opl_top_inc = LP_WE && (LP_ADDR == LOC_OPL_TOP_INC); // R03

    // four list pointers, each a circular register
    mqu_ring_ptr u_ofl_bot (
        .clk(SYS_CLK), .rst(RST), .ce(CE),
        .load(lw_ofl_bot), .load_val(LP_WDATA), .adv(lw_ofl_bot_inc),
        .base_hi(qbase_q), .mask(mask), .ptr_q(ofl_bot)
    ); // R01
    mqu_ring_ptr u_ofl_top (
        .clk(SYS_CLK), .rst(RST), .ce(CE),
        .load(lw_ofl_top), .load_val(LP_WDATA), .adv(ofl_top_adv),
        .base_hi(qbase_q), .mask(mask), .ptr_q(ofl_top)
    ); // R01
    mqu_ring_ptr u_opl_bot (
        .clk(SYS_CLK), .rst(RST), .ce(CE),
        .load(lw_opl_bot), .load_val(LP_WDATA), .adv(opl_bot_adv),
        .base_hi(qbase_q), .mask(mask), .ptr_q(opl_bot)
    ); // R01
    mqu_ring_ptr u_opl_top (
        .clk(SYS_CLK), .rst(RST), .ce(CE),
        .load(lw_opl_top), .load_val(LP_WDATA), .adv(lw_opl_top_inc),
        .base_hi(qbase_q), .mask(mask), .ptr_q(opl_top)
    ); // R01

    // control registers
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            msg_unit_enable_q <= 1'b0;
            host_msg_irq_route_q <= 1'b0;
            qbase_q <= QBASE_RST;
            qsize_q <= QSIZE_RST;
        end else if (CE) begin
            if (lw_ctrl) begin
                msg_unit_enable_q <= LP_WDATA[ENABLE_BIT];
                host_msg_irq_route_q <= LP_WDATA[ROUTE_BIT]; // R09
            end
            if (lw_qbase) begin
                qbase_q <= LP_WDATA[31:QBASE_LSB];
                qsize_q <= LP_WDATA[2:0];
            end
        end
    end

    // host writes to the mask register; status stays independent of it
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            post_list_irq_mask_bit_q <= 1'b0;
        end else if (CE && quick && hit_mask && HOST_WE) begin
            post_list_irq_mask_bit_q <= HOST_WDATA[MASK_BIT]; // R22 R24
        end
    end

    // host read data for the quick answers
    logic [31:0] quick_rdata;
    assign quick_rdata = hit_status ? (ZERO_WORD | (32'(post_list_service_request)
        << STATUS_BIT)) : hit_mask ? (ZERO_WORD | (32'(post_list_irq_mask_bit_q)
        << MASK_BIT)) : hit_outq ? EMPTY_READ : ZERO_WORD; // R23 R13

    // delayed read / delayed write sequencer toward local memory
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (rd_outq) begin
                    state_d = ST_RD;
                end else if (wr_outq) begin
                    state_d = ST_WR;
                end
            end
            ST_RD: begin
                if (MEM_ACK) begin
                    state_d = ST_IDLE;
                end
            end
            ST_WR: begin
                if (MEM_ACK) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
        end else if (CE) begin
            state_q <= state_d;
        end
    end

    // memory master: request held until the memory acknowledges
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
            MEM_ADDR <= ZERO_WORD;
            MEM_WDATA <= ZERO_WORD;
        end else if (CE) begin
            if (rd_outq) begin
                MEM_REQ <= 1'b1;
                MEM_WE <= 1'b0;
                MEM_ADDR <= opl_bot; // R10
            end else if (wr_outq) begin
                MEM_REQ <= 1'b1;
                MEM_WE <= 1'b1;
                MEM_ADDR <= ofl_top; // R15
                MEM_WDATA <= HOST_WDATA;
            end else if (MEM_ACK) begin
                MEM_REQ <= 1'b0;
                MEM_WE <= 1'b0;
            end
        end
    end

    // host answer: one-cycle acknowledge, data held until the next answer
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            HOST_ACK <= 1'b0;
            HOST_NOCLAIM <= 1'b0;
            HOST_RDATA <= ZERO_WORD;
        end else if (CE) begin
            HOST_ACK <= quick || ((state_q != ST_IDLE) && MEM_ACK);
            // disabled unit leaves the whole shell unclaimed
            HOST_NOCLAIM <= take && !msg_unit_enable_q; // R24
            if (quick && !HOST_WE) begin
                HOST_RDATA <= quick_rdata; // R13
            end else if (opl_bot_adv) begin
                HOST_RDATA <= MEM_RDATA;
            end
        end
    end

    // inbound port writes pass on untouched; pull flag only decoded
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            IN_POST_VALID <= 1'b0;
            IN_POST_DATA <= ZERO_WORD;
            IN_POST_PULL <= 1'b0;
        end else if (CE) begin
            IN_POST_VALID <= quick && hit_inq && HOST_WE; // R17
            if (quick && hit_inq && HOST_WE) begin
                IN_POST_DATA <= HOST_WDATA; // R17
                IN_POST_PULL <= HOST_WDATA[PULL_BIT]; // R16
            end
        end
    end

    // interrupt and its aliases
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            HOST_IRQ <= 1'b0;
            IRQ_STAT_ALIAS <= 1'b0;
            IRQ_MASK_ALIAS <= 1'b0;
        end else if (CE) begin
            HOST_IRQ <= post_list_service_request && !post_list_irq_mask_bit_q
                && host_msg_irq_route_q; // R05 R09
            IRQ_STAT_ALIAS <= post_list_service_request; // R08
            IRQ_MASK_ALIAS <= post_list_irq_mask_bit_q; // R08
        end
    end

    // local register readback
    logic [31:0] lp_mux;
    assign lp_mux = (LP_ADDR == LOC_CTRL) ? (ZERO_WORD
            | (32'(msg_unit_enable_q) << ENABLE_BIT)
            | (32'(host_msg_irq_route_q) << ROUTE_BIT))
        : (LP_ADDR == LOC_QBASE) ? {qbase_q, 17'h0_0000, qsize_q}
        : (LP_ADDR == LOC_OFL_BOT) ? ofl_bot
        : (LP_ADDR == LOC_OFL_TOP) ? ofl_top
        : (LP_ADDR == LOC_OPL_BOT) ? opl_bot
        : (LP_ADDR == LOC_OPL_TOP) ? opl_top
        : (LP_ADDR == LOC_ALIAS) ? (ZERO_WORD
            | (32'(post_list_service_request) << STATUS_BIT)
            | (32'(post_list_irq_mask_bit_q) << MASK_BIT)) // R08
        : ZERO_WORD;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            LP_RDATA <= ZERO_WORD;
        end else if (CE) begin
            LP_RDATA <= lp_mux;
        end
    end
endmodule // mqu_outbound_top
`default_nettype wire

// *** hdl/mqu_pkg.sv ***
// shared constants for the outbound message queue unit
package mqu_pkg;
    localparam int SHELL_AW = 12;
    localparam int LOC_AW = 6;
    // host shell offsets
    localparam logic [11:0] OFF_OPL_STATUS = 12'h030;
    localparam logic [11:0] OFF_OPL_MASK = 12'h034;
    localparam logic [11:0] OFF_IN_Q = 12'h040;
    localparam logic [11:0] OFF_OUT_Q = 12'h044;
    // field positions
    localparam int STATUS_BIT = 3;
    localparam int MASK_BIT = 3;
    localparam int PULL_BIT = 0;
    localparam int ENABLE_BIT = 0;
    localparam int ROUTE_BIT = 1;
    localparam int QBASE_LSB = 20;
    // local processor register offsets
    localparam logic [5:0] LOC_CTRL = 6'h00;
    localparam logic [5:0] LOC_QBASE = 6'h04;
    localparam logic [5:0] LOC_OFL_BOT = 6'h08;
    localparam logic [5:0] LOC_OFL_BOT_INC = 6'h0c;
    localparam logic [5:0] LOC_OFL_TOP = 6'h10;
    localparam logic [5:0] LOC_OPL_BOT = 6'h14;
    localparam logic [5:0] LOC_OPL_TOP = 6'h18;
    localparam logic [5:0] LOC_OPL_TOP_INC = 6'h1c;
    localparam logic [5:0] LOC_ALIAS = 6'h20;
    // values
    localparam logic [31:0] EMPTY_READ = 32'hffff_ffff;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [19:0] PTR_STEP = 20'h0_0004;
    localparam logic [19:0] RING_MIN = 20'h0_0400;
    localparam logic [31:0] PTR_RST = 32'h0000_0000;
    localparam logic [11:0] QBASE_RST = 12'h000;
    localparam logic [2:0] QSIZE_RST = 3'h0;

    // ring length in bytes is RING_MIN << sel
    function automatic logic [19:0] ring_mask(input logic [2:0] sel);
        ring_mask = (RING_MIN << sel) - 20'h0_0001;
    endfunction
endpackage

// *** hdl/mqu_ring_ptr.sv ***
// one circular-list pointer with load, advance and wrap
`timescale 1ns/1ps
`default_nettype none
module mqu_ring_ptr
    import mqu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic load,
    input wire logic [31:0] load_val,
    input wire logic adv,
    input wire logic [11:0] base_hi,
    input wire logic [19:0] mask,
    output logic [31:0] ptr_q
);
    logic [19:0] off_next;
    logic [31:0] ptr_d;

    // offset wraps inside the power-of-two ring
    assign off_next = (ptr_q[19:0] + PTR_STEP) & mask; // R25
    assign ptr_d = load ? load_val : adv ? {base_hi, off_next} : ptr_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_q <= PTR_RST;
        end else if (ce) begin
            ptr_q <= ptr_d;
        end
    end
endmodule // mqu_ring_ptr
`default_nettype wire

// *** tb/mqu_outbound_sva.sv ***
// concurrent checks on the outbound queue unit ports
`timescale 1ns/1ps
`default_nettype none
module mqu_outbound_sva
    import mqu_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic HOST_WE,
    input wire logic [SHELL_AW-1:0] HOST_ADDR,
    input wire logic [31:0] HOST_WDATA,
    input wire logic HOST_ACK,
    input wire logic HOST_NOCLAIM,
    input wire logic [31:0] HOST_RDATA,
    input wire logic HOST_IRQ,
    input wire logic MEM_REQ,
    input wire logic MEM_WE,
    input wire logic [31:0] MEM_ADDR,
    input wire logic [31:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic [31:0] MEM_RDATA,
    input wire logic IN_POST_VALID,
    input wire logic [31:0] IN_POST_DATA,
    input wire logic IN_POST_PULL,
    input wire logic IRQ_STAT_ALIAS,
    input wire logic IRQ_MASK_ALIAS
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence s_mem_wait;
        MEM_REQ && !MEM_ACK;
    endsequence
    sequence s_mem_done;
        MEM_REQ && MEM_ACK;
    endsequence
    // answer without a memory cycle to a read of offset a
    sequence s_quick(a);
        HOST_ACK && !$past(MEM_REQ) && !$past(HOST_WE) && $past(HOST_ADDR) == a;
    endsequence
    a_mem_hold: assert property (s_mem_wait |=> MEM_REQ && $stable(MEM_ADDR))
        else $error("memory request moved before ack");
    a_read_done: assert property (s_mem_done ##0 !MEM_WE |=>
        HOST_ACK && !MEM_REQ && HOST_RDATA == $past(MEM_RDATA))
        else $error("queue read not answered with memory word");
    a_write_done: assert property (s_mem_done ##0 MEM_WE |=> HOST_ACK && !MEM_REQ)
        else $error("queue write not completed");
    a_free_store: assert property ($rose(MEM_REQ) && MEM_WE |->
        MEM_WDATA == $past(HOST_WDATA) && $past(HOST_ADDR) == OFF_OUT_Q)
        else $error("free list store data wrong");
    a_empty_read: assert property (s_quick(OFF_OUT_Q) |-> HOST_RDATA == EMPTY_READ)
        else $error("empty queue read not all ones");
    a_status_view: assert property (s_quick(OFF_OPL_STATUS) |->
        HOST_RDATA[STATUS_BIT] == IRQ_STAT_ALIAS)
        else $error("status bit and alias disagree");
    a_irq_gate: assert property (HOST_IRQ |-> IRQ_STAT_ALIAS && !IRQ_MASK_ALIAS)
        else $error("interrupt without unmasked status");
    a_inbound_pass: assert property (IN_POST_VALID |-> HOST_ACK &&
        IN_POST_DATA == $past(HOST_WDATA) && IN_POST_PULL == $past(HOST_WDATA[PULL_BIT]))
        else $error("inbound word altered");
    a_noclaim_quiet: assert property (HOST_NOCLAIM |-> !HOST_ACK && !MEM_REQ)
        else $error("disabled unit answered");
endmodule // mqu_outbound_sva
bind mqu_outbound_top mqu_outbound_sva u_sva (
    .SYS_CLK(SYS_CLK), .RST(RST), .HOST_WE(HOST_WE), .HOST_ADDR(HOST_ADDR),
    .HOST_WDATA(HOST_WDATA), .HOST_ACK(HOST_ACK), .HOST_NOCLAIM(HOST_NOCLAIM),
    .HOST_RDATA(HOST_RDATA), .HOST_IRQ(HOST_IRQ), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
    .IN_POST_VALID(IN_POST_VALID), .IN_POST_DATA(IN_POST_DATA),
    .IN_POST_PULL(IN_POST_PULL), .IRQ_STAT_ALIAS(IRQ_STAT_ALIAS),
    .IRQ_MASK_ALIAS(IRQ_MASK_ALIAS)
);
`default_nettype wire

// *** tb/mqu_mem_model.sv ***
// local memory answering the unit's list reads and writes
`timescale 1ns/1ps
`default_nettype none
module mqu_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic we,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] lat,
    output logic ack,
    output logic [31:0] rdata
);
    logic [31:0] mem [256];
    logic [3:0] cnt;
    // idle read bus toggles so stale data never looks valid
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (rst) begin
            cnt <= 4'h0;
            rdata <= 32'h0000_0000;
        end else if (req && !ack) begin
            cnt <= cnt + 4'h1;
            if (cnt >= lat) begin
                ack <= 1'b1;
                cnt <= 4'h0;
                if (we)
                    mem[addr[9:2]] <= wdata;
                else
                    rdata <= mem[addr[9:2]];
            end
        end
    end
endmodule // mqu_mem_model
`default_nettype wire

// *** tb/mqu_outbound_top_tb.sv ***
// self-checking bench for the outbound queue unit
`timescale 1ns/1ps
`default_nettype none
module mqu_outbound_top_tb;
    import mqu_pkg::*;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    localparam logic [31:0] B3 = 32'h0000_0008;
    logic clk, ce, rst, hreq, hwe, hack, hnc, irq, mreq, mwe, mack, lwe, ipv, ipp, sal, mal;
    logic [11:0] haddr;
    logic [5:0] laddr;
    logic [31:0] hwd, hrd, maddr, mwd, mrd, lwd, lrd, ipd, r;
    logic [3:0] lat;
    logic [1:0] resp;
    logic [5:0] pr [4] = '{LOC_OFL_BOT, LOC_OFL_TOP, LOC_OPL_BOT, LOC_OPL_TOP};
    int n_fail, checks_done;
    mqu_outbound_top DUT (.SYS_CLK(clk), .RST(rst), .CE(ce), .HOST_REQ(hreq),
        .HOST_WE(hwe), .HOST_ADDR(haddr), .HOST_WDATA(hwd), .HOST_ACK(hack),
        .HOST_NOCLAIM(hnc), .HOST_RDATA(hrd), .HOST_IRQ(irq), .MEM_REQ(mreq), .MEM_WE(mwe),
        .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_ACK(mack), .MEM_RDATA(mrd), .LP_WE(lwe),
        .LP_ADDR(laddr), .LP_WDATA(lwd), .LP_RDATA(lrd), .IN_POST_VALID(ipv),
        .IN_POST_DATA(ipd), .IN_POST_PULL(ipp), .IRQ_STAT_ALIAS(sal), .IRQ_MASK_ALIAS(mal));
    mqu_mem_model mem_i (.clk(clk), .rst(rst), .req(mreq), .we(mwe), .addr(maddr),
        .wdata(mwd), .lat(lat), .ack(mack), .rdata(mrd));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic host(input logic we, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hreq <= 1'b1;
        hwe <= we;
        haddr <= a;
        hwd <= d;
        resp = 2'b00;
        for (int i = 0; i < 60 && resp == 2'b00; i++) begin
            @(posedge clk);
            resp = {hnc, hack};
        end
        r = hrd;
        // an access that is never answered counts as a mismatch
        if (resp == 2'b00) n_fail++;
        hreq <= 1'b0;
    endtask
    task automatic hr(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        host(1'b0, a, ZERO_WORD);
        check(32'(resp), 32'h0000_0001);
        check(r & m, exp);
    endtask
    task automatic lpw(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        lwe <= 1'b1;
        laddr <= a;
        lwd <= d;
        @(posedge clk);
        lwe <= 1'b0;
    endtask
    task automatic lpr(input logic [5:0] a, input logic [31:0] exp);
        @(posedge clk);
        laddr <= a;
        @(posedge clk);
        #1 check(lrd, exp);
    endtask
    // levels lag their cause by a cycle or two
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks=%0d fails=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        give_verdict;
    end
    initial begin
        {ce, rst, hreq, hwe, lwe, haddr, laddr, hwd, lwd, lat} = {5'b11000, 18'h0, 64'h0, 4'h0};
        n_fail = 0;
        checks_done = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (pr[k]) lpr(pr[k], PTR_RST);
        host(1'b1, OFF_OPL_MASK, B3);
        host(1'b0, OFF_OPL_STATUS, ZERO_WORD);
        check(32'(resp), 32'h0000_0002);
        $display("test reset done");
        lpw(LOC_CTRL, 32'h0000_0003);
        hr(OFF_OPL_MASK, ZERO_WORD, B3);
        hr(OFF_OUT_Q, EMPTY_READ, ALL);
        hr(OFF_OPL_STATUS, ZERO_WORD, B3);
        $display("test enable done");
        for (int k = 0; k < 2; k++) begin
            mem_i.mem[k] = 32'h0000_1000 + 32'(k) * 32'h0000_0100;
            lpw(LOC_OPL_TOP_INC, 32'h0000_0001);
        end
        lpr(LOC_OPL_TOP, 32'h0000_0008);
        settle;
        check(32'(irq), 32'h0000_0001);
        check(32'(sal), 32'h0000_0001);
        lpr(LOC_ALIAS, B3);
        // route off: status alone must not reach the pin
        lpw(LOC_CTRL, 32'h0000_0001);
        settle;
        check(32'(irq), 32'h0000_0000);
        lpw(LOC_CTRL, 32'h0000_0003);
        lpr(LOC_CTRL, 32'h0000_0003);
        hr(OFF_OPL_STATUS, B3, B3);
        host(1'b1, OFF_OPL_MASK, B3);
        settle;
        check(32'(irq), 32'h0000_0000);
        check(32'(mal), 32'h0000_0001);
        hr(OFF_OPL_STATUS, B3, B3);
        host(1'b1, OFF_OPL_MASK, ZERO_WORD);
        settle;
        check(32'(irq), 32'h0000_0001);
        $display("test post done");
        lat = 4'h3;
        hr(OFF_OUT_Q, 32'h0000_1000, ALL);
        hr(OFF_OUT_Q, 32'h0000_1100, ALL);
        lpr(LOC_OPL_BOT, 32'h0000_0008);
        settle;
        check(32'(irq), 32'h0000_0000);
        hr(OFF_OPL_STATUS, ZERO_WORD, B3);
        hr(OFF_OUT_Q, EMPTY_READ, ALL);
        // enable low: a pointer strobe must be lost
        ce <= 1'b0;
        lpw(LOC_OPL_TOP_INC, 32'h0000_0001);
        ce <= 1'b1;
        lpr(LOC_OPL_TOP, 32'h0000_0008);
        $display("test drain done");
        for (int k = 0; k < 2; k++) begin
            host(1'b1, OFF_OUT_Q, 32'h0000_1100 - 32'(k) * 32'h0000_0100);
            check(mem_i.mem[k], 32'h0000_1100 - 32'(k) * 32'h0000_0100);
        end
        lpr(LOC_OFL_TOP, 32'h0000_0008);
        lpw(LOC_OFL_BOT_INC, 32'h0000_0001);
        lpr(LOC_OFL_BOT, 32'h0000_0004);
        lpw(LOC_OFL_BOT, 32'h0000_03fc);
        lpw(LOC_OFL_BOT_INC, 32'h0000_0001);
        lpr(LOC_OFL_BOT, PTR_RST);
        for (int k = 0; k < 2; k++) begin
            host(1'b1, OFF_IN_Q, 32'h0000_2000 + 32'(k) * 32'h0000_000f);
            check(32'(ipv), 32'h0000_0001);
            check(ipd, 32'h0000_2000 + 32'(k) * 32'h0000_000f);
            check(32'(ipp), 32'(k));
        end
        $display("test return done");
        lpw(LOC_QBASE, 32'h0010_0000);
        lpw(LOC_OPL_BOT, 32'h0010_03fc);
        lpw(LOC_OPL_TOP, 32'h0010_03fc);
        mem_i.mem[255] = 32'h0000_3000;
        lpw(LOC_OPL_TOP_INC, 32'h0000_0001);
        lpr(LOC_OPL_TOP, 32'h0010_0000);
        hr(OFF_OUT_Q, 32'h0000_3000, ALL);
        lpr(LOC_OPL_BOT, 32'h0010_0000);
        // doubled ring: no wrap at the first kilobyte
        lpw(LOC_QBASE, 32'h0010_0001);
        lpr(LOC_QBASE, 32'h0010_0001);
        lpw(LOC_OPL_TOP, 32'h0010_03fc);
        lpw(LOC_OPL_TOP_INC, 32'h0000_0001);
        lpr(LOC_OPL_TOP, 32'h0010_0400);
        $display("test wrap done");
        give_verdict;
    end
endmodule // mqu_outbound_top_tb
`default_nettype wire
